/* File: design/acgc_top.v */
/*
 * Audio clock generator configuration: AXI4-Lite register file, PLL
 * watchdog and three fractional audio rate generators, the third with
 * a selectable reference.
 * Assumes all inputs are synchronous to ref_clk_i and that the PLL
 * itself, with its own settings, sits outside this block.
 */
`include "acgc_consts.vh"

module acgc_top #(
    parameter LOCK_WAIT_CYC = `ACGC_LOCK_WAIT_CYC
) (
    input wire ref_clk_i,
    input wire resetn_i,
    // AXI4-Lite write address channel
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [`ACGC_ADDR_W-1:0] s_axi_awaddr_i,
    input wire [2:0] s_axi_awprot_i,
    // AXI4-Lite write data channel
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    // AXI4-Lite write response channel
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    output reg [1:0] s_axi_bresp_o,
    // AXI4-Lite read address channel
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    input wire [`ACGC_ADDR_W-1:0] s_axi_araddr_i,
    input wire [2:0] s_axi_arprot_i,
    // AXI4-Lite read data channel
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    // PLL supervision
    input wire pll_run_i,
    input wire pll_lock_i,
    output wire pll_reset_o,
    // External references for generator 3
    input wire [15:0] multipurpose_pin_i,
    input wire spdif_ref_i,
    // Generator output rate enables, bit n for generator n+1
    output wire [2:0] gen_tick_o
);

    // Write side holding registers
    reg aw_hold_reg;            // Write address taken, not yet used
    reg [`ACGC_ADDR_W-1:0] aw_addr_reg;  // Held write address
    reg w_hold_reg;             // Write data taken, not yet used
    reg [15:0] w_data_reg;      // Held write data, low half only
    reg [1:0] w_strb_reg;       // Held strobes of the low half

    // Configuration registers
    reg wdog_en_reg;                          // Watchdog enable
    reg [`ACGC_NARROW_W-1:0] gen1_denominator;  // Generator 1 M
    reg [`ACGC_NARROW_W-1:0] gen1_numerator;    // Generator 1 N
    reg [`ACGC_NARROW_W-1:0] gen2_denominator;  // Generator 2 M
    reg [`ACGC_NARROW_W-1:0] gen2_numerator;    // Generator 2 N
    reg [`ACGC_WIDE_W-1:0] gen3_denominator;    // Generator 3 M
    reg [`ACGC_WIDE_W-1:0] gen3_numerator;      // Generator 3 N
    reg [`ACGC_SRC_W-1:0] gen3_src_reg;         // Generator 3 source

    // Reference edge detection
    reg ext_prev_reg;           // Selected reference, last cycle

    // Watchdog status
    wire wdog_recover;          // PLL held in reset by the watchdog
    wire [7:0] wdog_retry;      // Recovery count

    // Decode and combinational read data
    wire wr_go;                 // Address and data both held
    wire [15:0] wr_idx;         // Register index of the write
    wire [15:0] rd_idx;         // Register index of the read
    wire [15:0] wmask;          // Bit mask from the byte strobes
    reg wr_hit;                 // Write index is mapped
    reg rd_hit;                 // Read index is mapped
    reg [15:0] rd_data;         // Read value, reserved bits zero

    // Generator 3 reference selection
    wire gen3_ext;              // External reference selected
    wire [3:0] gen3_ref_pin_select;  // Which pin feeds it
    wire ext_level;             // Level of the selected reference
    wire ext_tick;              // Rising edge of that reference

    // Per generator numerators, denominators and reference ticks
    wire [3*`ACGC_WIDE_W-1:0] num_vec;
    wire [3*`ACGC_WIDE_W-1:0] den_vec;
    wire [2:0] ref_tick_vec;

    // Handshakes: take a channel only while its slot is free
    assign s_axi_awready_o = !aw_hold_reg && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_hold_reg && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid_o;
    assign wr_idx = aw_addr_reg[`ACGC_ADDR_W-1:2];
    assign rd_idx = s_axi_araddr_i[`ACGC_ADDR_W-1:2];
    assign wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    // Capture write address and write data in either order
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= {`ACGC_ADDR_W{1'b0}};
            w_hold_reg <= 1'b0;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                // Address taken and held until the write is done
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end else if (wr_go) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                // Only the low half word holds register bits
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i[15:0];
                w_strb_reg <= s_axi_wstrb_i[1:0];
            end else if (wr_go) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // Write index decode
    always @* begin
        case (wr_idx)
            `ACGC_IDX_WDOG,
            `ACGC_IDX_G1_DEN,
            `ACGC_IDX_G1_NUM,
            `ACGC_IDX_G2_DEN,
            `ACGC_IDX_G2_NUM,
            `ACGC_IDX_G3_DEN,
            `ACGC_IDX_G3_NUM,
            `ACGC_IDX_G3_SRC,
            `ACGC_IDX_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Register writes; reserved bits are simply not stored
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            wdog_en_reg <= `ACGC_RST_WDOG;
            gen1_denominator <= `ACGC_RST_G1_DEN;
            gen1_numerator <= `ACGC_RST_G1_NUM;
            gen2_denominator <= `ACGC_RST_G2_DEN;
            gen2_numerator <= `ACGC_RST_G2_NUM;
            gen3_denominator <= `ACGC_RST_G3_DEN;
            gen3_numerator <= `ACGC_RST_G3_NUM;
            gen3_src_reg <= `ACGC_RST_G3_SRC;
        end else if (wr_go) begin
            case (wr_idx)
                `ACGC_IDX_WDOG: begin
                    // Bit 0 enables supervision
                    if (w_strb_reg[0]) begin
                        wdog_en_reg <= w_data_reg[`ACGC_WDOG_EN_BIT];
                    end
                end
                `ACGC_IDX_G1_DEN: begin
                    gen1_denominator <= (gen1_denominator & ~wmask[8:0])
                        | (w_data_reg[8:0] & wmask[8:0]);
                end
                `ACGC_IDX_G1_NUM: begin
                    gen1_numerator <= (gen1_numerator & ~wmask[8:0])
                        | (w_data_reg[8:0] & wmask[8:0]);
                end
                `ACGC_IDX_G2_DEN: begin
                    gen2_denominator <= (gen2_denominator & ~wmask[8:0])
                        | (w_data_reg[8:0] & wmask[8:0]);
                end
                `ACGC_IDX_G2_NUM: begin
                    gen2_numerator <= (gen2_numerator & ~wmask[8:0])
                        | (w_data_reg[8:0] & wmask[8:0]);
                end
                `ACGC_IDX_G3_DEN: begin
                    gen3_denominator <= (gen3_denominator & ~wmask)
                        | (w_data_reg & wmask);
                end
                `ACGC_IDX_G3_NUM: begin
                    gen3_numerator <= (gen3_numerator & ~wmask)
                        | (w_data_reg & wmask);
                end
                `ACGC_IDX_G3_SRC: begin
                    // Bits 15:5 are dropped
                    gen3_src_reg <= (gen3_src_reg & ~wmask[4:0])
                        | (w_data_reg[4:0] & wmask[4:0]);
                end
                default: begin
                    // Status and unmapped writes change nothing
                end
            endcase
        end
    end

    // Write response: one cycle after both halves are held
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `ACGC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? `ACGC_RESP_OKAY : `ACGC_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            // Response held until the master takes it
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read mux; every unused bit reads as zero
    always @* begin
        rd_hit = 1'b1;
        rd_data = 16'h0000;
        case (rd_idx)
            `ACGC_IDX_WDOG: rd_data[`ACGC_WDOG_EN_BIT] = wdog_en_reg;
            `ACGC_IDX_G1_DEN: rd_data[8:0] = gen1_denominator;
            `ACGC_IDX_G1_NUM: rd_data[8:0] = gen1_numerator;
            `ACGC_IDX_G2_DEN: rd_data[8:0] = gen2_denominator;
            `ACGC_IDX_G2_NUM: rd_data[8:0] = gen2_numerator;
            `ACGC_IDX_G3_DEN: rd_data = gen3_denominator;
            `ACGC_IDX_G3_NUM: rd_data = gen3_numerator;
            `ACGC_IDX_G3_SRC: rd_data[4:0] = gen3_src_reg;
            `ACGC_IDX_STATUS: begin
                // Live watchdog view for software
                rd_data[`ACGC_STAT_LOCK_BIT] = pll_lock_i;
                rd_data[`ACGC_STAT_RECOV_BIT] = wdog_recover;
                rd_data[15:`ACGC_STAT_RETRY_LSB] = wdog_retry;
            end
            default: begin
                // Unmapped: zero data, error answer
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: data one cycle after the address is taken
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `ACGC_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {16'h0000, rd_data};
            s_axi_rresp_o <= rd_hit ? `ACGC_RESP_OKAY : `ACGC_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            // Data held until the master takes it
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // Generator 3 reference: PLL, a multipurpose pin or S/PDIF
    assign gen3_ext = gen3_src_reg[`ACGC_SRC_EXT_BIT];
    assign gen3_ref_pin_select =
        gen3_src_reg[`ACGC_SRC_PIN_MSB:`ACGC_SRC_PIN_LSB];
    // Code 0xE takes the S/PDIF receiver
    assign ext_level = (gen3_ref_pin_select == `ACGC_SRC_SPDIF)
        ? spdif_ref_i : multipurpose_pin_i[gen3_ref_pin_select];
    // One tick per rising edge; duty cycle left to the source
    assign ext_tick = ext_level && !ext_prev_reg;

    // Remember the selected reference level for edge detection
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_level;
        end
    end

    // Generators 1 and 2 always run from the PLL clock
    assign num_vec[15:0] = {7'h00, gen1_numerator};
    assign den_vec[15:0] = {7'h00, gen1_denominator};
    assign num_vec[31:16] = {7'h00, gen2_numerator};
    assign den_vec[31:16] = {7'h00, gen2_denominator};
    assign num_vec[47:32] = gen3_numerator;
    // External reference divides by 1024 and ignores M
    assign den_vec[47:32] = gen3_ext ? `ACGC_EXT_DIVISOR
        : gen3_denominator;
    assign ref_tick_vec[1:0] = 2'h3;
    assign ref_tick_vec[2] = gen3_ext ? ext_tick : 1'b1;

    // Output rate = reference rate * N / M
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_gen
            acgc_ratio_gen #(
                .W(`ACGC_WIDE_W)
            ) u_ratio (
                .ref_clk_i(ref_clk_i),
                .resetn_i(resetn_i),
                .ref_tick_i(ref_tick_vec[gi]),
                .num_i(num_vec[gi*16+15:gi*16]),
                .den_i(den_vec[gi*16+15:gi*16]),
                .tick_o(gen_tick_o[gi])
            );
        end
    endgenerate

    // Watchdog: resets the PLL core only; all settings stay put
    acgc_pll_watchdog #(
        .LOCK_WAIT_CYC(LOCK_WAIT_CYC),
        .HOLD_CYC(`ACGC_PLL_HOLD_CYC)
    ) u_wdog (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .enable_i(wdog_en_reg),
        .pll_run_i(pll_run_i),
        .pll_lock_i(pll_lock_i),
        .pll_reset_o(pll_reset_o),
        .recovering_o(wdog_recover),
        .retry_o(wdog_retry)
    );

endmodule // acgc_top

/* File: pkg/acgc_consts.vh */
/*
 * Constants of the audio clock generator configuration block: register
 * indices, field positions, reset values, timing counts, bus answers.
 * Assumes it is included by bare name from the design files.
 */
`ifndef ACGC_CONSTS_VH
`define ACGC_CONSTS_VH

// Register indices; the byte address is four times the index
`define ACGC_IDX_WDOG 16'hf006
`define ACGC_IDX_G1_DEN 16'hf020
`define ACGC_IDX_G1_NUM 16'hf021
`define ACGC_IDX_G2_DEN 16'hf022
`define ACGC_IDX_G2_NUM 16'hf023
`define ACGC_IDX_G3_DEN 16'hf024
`define ACGC_IDX_G3_NUM 16'hf025
`define ACGC_IDX_G3_SRC 16'hf026
`define ACGC_IDX_STATUS 16'hf030
`define ACGC_ADDR_W 18

// Field widths
`define ACGC_NARROW_W 9
`define ACGC_WIDE_W 16
`define ACGC_SRC_W 5

// Reset values
`define ACGC_RST_WDOG 1'h1
`define ACGC_RST_G1_DEN 9'h006
`define ACGC_RST_G1_NUM 9'h001
`define ACGC_RST_G2_DEN 9'h009
`define ACGC_RST_G2_NUM 9'h001
`define ACGC_RST_G3_DEN 16'h0000
`define ACGC_RST_G3_NUM 16'h0000
`define ACGC_RST_G3_SRC 5'h0e

// Field positions
`define ACGC_WDOG_EN_BIT 0
`define ACGC_SRC_EXT_BIT 4
`define ACGC_SRC_PIN_MSB 3
`define ACGC_SRC_PIN_LSB 0
`define ACGC_SRC_SPDIF 4'he
`define ACGC_EXT_DIVISOR 16'h0400
`define ACGC_STAT_LOCK_BIT 0
`define ACGC_STAT_RECOV_BIT 1
`define ACGC_STAT_RETRY_LSB 8

// Timing: clock rate, PLL reset hold (least), lock wait
`define ACGC_CLK_MHZ 250
`define ACGC_PLL_HOLD_NS 1000
`define ACGC_PLL_HOLD_CYC ((`ACGC_PLL_HOLD_NS*`ACGC_CLK_MHZ+999)/1000)
`define ACGC_LOCK_WAIT_US 100
`define ACGC_LOCK_WAIT_CYC (`ACGC_LOCK_WAIT_US*`ACGC_CLK_MHZ)

// Bus answers
`define ACGC_RESP_OKAY 2'h0
`define ACGC_RESP_SLVERR 2'h2

`endif

/* File: design/acgc_ratio_gen.v */
/*
 * Fractional rate generator: emits enable pulses at the reference
 * tick rate times num_i / den_i, by a phase accumulator.
 * Assumes one clock and a synchronous active-low reset.
 */
`include "acgc_consts.vh"

module acgc_ratio_gen #(
    parameter W = 16
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire ref_tick_i,     // One reference period has passed
    input wire [W-1:0] num_i,  // Numerator N
    input wire [W-1:0] den_i,  // Denominator M
    output reg tick_o          // One output period has passed
);

    reg [W:0] acc_reg;    // Phase accumulator
    reg [W:0] acc_next;   // Next accumulator value
    reg tick_next;        // Next output pulse
    reg [W+1:0] sum;      // Accumulator plus numerator
    reg [W+1:0] rem;      // Sum less one denominator

    // Add N per reference tick, take M away per output pulse
    always @* begin
        sum = {1'b0, acc_reg} + (ref_tick_i ? {2'h0, num_i} : {(W+2){1'b0}});
        rem = sum - {2'h0, den_i};
        acc_next = sum[W:0];
        tick_next = 1'b0;
        if (den_i == {W{1'b0}}) begin
            // Zero denominator: generator stands still
            acc_next = {(W+1){1'b0}};
        end else if (sum >= {2'h0, den_i}) begin
            // One pulse per clock at most; excess phase saturates
            tick_next = 1'b1;
            acc_next = rem[W+1] ? {(W+1){1'b1}} : rem[W:0];
        end
    end

    // Accumulator and output flip-flops
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            acc_reg <= {(W+1){1'b0}};
            tick_o <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            tick_o <= tick_next;
        end
    end

endmodule // acgc_ratio_gen

/* File: design/acgc_pll_watchdog.v */
/*
 * PLL watchdog: watches the lock flag, pulses the PLL reset when lock
 * is lost or never comes, then lets the PLL lock again.
 * Assumes the PLL keeps its settings across its own reset.
 */
`include "acgc_consts.vh"

module acgc_pll_watchdog #(
    parameter LOCK_WAIT_CYC = `ACGC_LOCK_WAIT_CYC,
    parameter HOLD_CYC = `ACGC_PLL_HOLD_CYC
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire enable_i,        // Supervision enabled
    input wire pll_run_i,       // PLL is switched on
    input wire pll_lock_i,      // PLL reports lock
    output reg pll_reset_o,     // Reset to the PLL core
    output reg recovering_o,    // Watchdog is recovering the PLL
    output reg [7:0] retry_o    // Recoveries so far, saturating
);

    localparam ST_IDLE = 2'h0;     // Not supervising
    localparam ST_ACQUIRE = 2'h1;  // Waiting for lock
    localparam ST_LOCKED = 2'h2;   // Lock held
    localparam ST_RECOVER = 2'h3;  // Holding the PLL in reset

    reg [1:0] state_reg;   // Current state
    reg [1:0] state_next;  // Next state
    reg [31:0] cnt_reg;    // Cycle counter of the current state
    reg [31:0] cnt_next;   // Next counter value
    reg bump;              // A recovery starts this cycle

    // Next state: unstable means lock lost or lock overdue
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg + 32'h1;
        bump = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                cnt_next = 32'h0;
                if (enable_i && pll_run_i) begin
                    state_next = ST_ACQUIRE;
                end
            end
            ST_ACQUIRE: begin
                if (pll_lock_i) begin
                    state_next = ST_LOCKED;
                end else if (cnt_reg == LOCK_WAIT_CYC - 1) begin
                    state_next = ST_RECOVER;
                    cnt_next = 32'h0;
                    bump = 1'b1;
                end
            end
            ST_LOCKED: begin
                cnt_next = 32'h0;
                if (!pll_lock_i) begin
                    state_next = ST_RECOVER;
                    bump = 1'b1;
                end
            end
            ST_RECOVER: begin
                if (cnt_reg == HOLD_CYC - 1) begin
                    // Release and lock again as before
                    state_next = ST_ACQUIRE;
                    cnt_next = 32'h0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Disabled or PLL off: supervision stops at once
        if (!enable_i || !pll_run_i) begin
            state_next = ST_IDLE;
            cnt_next = 32'h0;
            bump = 1'b0;
        end
    end

    // State, counter and registered outputs
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 32'h0;
            pll_reset_o <= 1'b0;
            recovering_o <= 1'b0;
            retry_o <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pll_reset_o <= (state_next == ST_RECOVER);
            recovering_o <= (state_next == ST_RECOVER);
            if (bump && retry_o != 8'hff) begin
                retry_o <= retry_o + 8'h01;
            end
        end
    end

endmodule // acgc_pll_watchdog

/* File: tb/acgc_top_asserts.sv */
/* Checker for acgc_top: bus handshakes and PLL watchdog relations.
   Assumes it is bound to acgc_top and sees only its ports. */
module acgc_top_asserts (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [1:0] s_axi_bresp_o,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire [31:0] s_axi_rdata_o,
    input wire pll_run_i,
    input wire pll_lock_i,
    input wire pll_reset_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // Address and data of a write taken at one edge
    sequence s_wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    // Response rises at the register update edge, one edge after the take
    sequence s_wr_answer;
        !s_axi_bvalid_o ##1 s_axi_bvalid_o;
    endsequence
    chk_wr_latency: assert property (s_wr_take |=> s_wr_answer)
        else $error("write answer out of time");
    chk_rd_latency: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    chk_r_upper: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_busy_block: assert property ((s_axi_bvalid_o |-> !s_axi_awready_o
        && !s_axi_wready_o) and (s_axi_rvalid_o |-> !s_axi_arready_o))
        else $error("request taken while busy");
    chk_loss_fire: assert property (
        pll_run_i && !pll_reset_o && $fell(pll_lock_i) |=> pll_reset_o)
        else $error("lock loss not answered");
    chk_run_gate: assert property (!pll_run_i |=> !pll_reset_o)
        else $error("PLL reset while switched off");
    chk_hold_len: assert property (
        $rose(pll_reset_o) && pll_run_i |=> pll_reset_o [*8])
        else $error("PLL reset pulse too short");
endmodule // acgc_top_asserts

bind acgc_top acgc_top_asserts chk_u (.*);

/* File: tb/test_audio_clock_generator_config.sv */
/* Testbench for acgc_top: registers over AXI4-Lite, rates, watchdog.
   Assumes acgc_top and its checker are compiled alongside. */
module test_audio_clock_generator_config;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] a, r, w, b;} acgc_row_t;
    logic ref_clk_i = 0, resetn_i = 0, spdif_ref_i = 0;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic pll_run_i = 0, pll_lock_i = 0;
    logic [17:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [2:0] s_axi_awprot_i = 0, s_axi_arprot_i = 0;
    logic [31:0] s_axi_wdata_i = 0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic [15:0] multipurpose_pin_i = 0;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    wire s_axi_rvalid_o, pll_reset_o;
    wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0] s_axi_rdata_o;
    wire [2:0] gen_tick_o;
    wire [3:0] obs = {pll_reset_o, gen_tick_o}; // Counted outputs
    int miscompares = 0, n_checks = 0, cyc = 0, cnt [4];
    // Reset value, value written, value read back
    acgc_row_t rows [8] = '{
        '{32'hf006, 32'h1, 32'hfffe, 32'h0},
        '{32'hf020, 32'h6, 32'hffff, 32'h1ff},
        '{32'hf021, 32'h1, 32'hffff, 32'h1ff},
        '{32'hf022, 32'h9, 32'hffff, 32'h1ff},
        '{32'hf023, 32'h1, 32'hffff, 32'h1ff},
        '{32'hf024, 32'h0, 32'h1ffff, 32'hffff},
        '{32'hf025, 32'h0, 32'hffff, 32'hffff},
        '{32'hf026, 32'he, 32'hffff, 32'h1f}};

    acgc_top #(.LOCK_WAIT_CYC(50)) dut_u (.*);

    always #2 ref_clk_i = ~ref_clk_i;

    // References: pin 3 period 8, S/PDIF period 16; hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        multipurpose_pin_i <= {12'h000, cyc[2], 3'h0};
        spdif_ref_i <= cyc[3];
        if (cyc == 20000) begin
            miscompares++;
            test_done;
        end
    end

    task automatic test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Compare, exact or within a tolerance; unknowns always fail
    task automatic chk(input logic [31:0] got, exp, input int tol = 0);
        n_checks++;
        if ($isunknown(got) || (tol == 0 ? got !== exp
                : (got + tol < exp || got > exp + tol))) begin
            miscompares++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // AXI4-Lite write; each channel released when taken; bready may
    // lag bvalid by lag cycles so that the held answer is exercised
    task automatic wr(input logic [31:0] a, d, input logic [1:0] r,
                      input int lag = 0);
        bit aw = 1, w = 1;
        s_axi_awaddr_i <= {a[15:0], 2'b00};
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= (lag == 0);
        do begin
            @(posedge ref_clk_i);
            if (aw && s_axi_awready_o) begin
                s_axi_awvalid_i <= 0;
                aw = 0;
            end
            if (w && s_axi_wready_o) begin
                s_axi_wvalid_i <= 0;
                w = 0;
            end
            if (s_axi_bvalid_o && lag > 0) begin
                lag--;
                s_axi_bready_i <= (lag == 0);
            end
        end while (!(s_axi_bvalid_o && s_axi_bready_i && !aw && !w));
        s_axi_bready_i <= 0;
        chk(s_axi_bresp_o, r);
        // One edge between calls keeps bready to one change a step
        @(posedge ref_clk_i);
    endtask

    // AXI4-Lite read and compare; rready may lag rvalid likewise
    task automatic rd(input logic [31:0] a, e, input logic [1:0] r,
                      input int lag = 0);
        s_axi_araddr_i <= {a[15:0], 2'b00};
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= (lag == 0);
        do begin
            @(posedge ref_clk_i);
            if (s_axi_arready_o)
                s_axi_arvalid_i <= 0;
            if (s_axi_rvalid_o && lag > 0) begin
                lag--;
                s_axi_rready_i <= (lag == 0);
            end
        end while (!(s_axi_rvalid_o && s_axi_rready_i));
        s_axi_rready_i <= 0;
        chk(s_axi_rdata_o, e);
        chk(s_axi_rresp_o, r);
        @(posedge ref_clk_i);
    endtask

    // Count ticks and PLL reset cycles over a window
    task automatic span(input int n);
        cnt = '{0, 0, 0, 0};
        repeat (n) begin
            @(posedge ref_clk_i);
            foreach (cnt[i]) cnt[i] += obs[i];
        end
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1;
        @(posedge ref_clk_i);
        foreach (rows[i]) begin
            rd(rows[i].a, rows[i].r, 2'h0);
            wr(rows[i].a, rows[i].w, 2'h0);
            rd(rows[i].a, rows[i].b, 2'h0);
        end
        wr(32'hf006, 32'h1, 2'h0);
        // Unmapped index; answers taken two cycles late
        wr(32'h0, 32'h5, 2'h2, 2);
        rd(32'h0, 32'h0, 2'h2, 2);
        $display("registers done");
        // Zero M clears the phase; N before M so none builds up
        wr(32'hf020, 32'h0, 2'h0);
        wr(32'hf022, 32'h0, 2'h0);
        wr(32'hf021, 32'h1, 2'h0);
        wr(32'hf023, 32'h3, 2'h0);
        wr(32'hf020, 32'h4, 2'h0);
        wr(32'hf022, 32'h8, 2'h0);
        wr(32'hf024, 32'h2, 2'h0);
        wr(32'hf025, 32'h1, 2'h0);
        wr(32'hf026, 32'h0, 2'h0);
        span(400);
        chk(cnt[0], 100, 2);
        chk(cnt[1], 150, 2);
        chk(cnt[2], 200, 2);
        wr(32'hf024, 32'h0, 2'h0);
        wr(32'hf025, 32'h400, 2'h0);
        wr(32'hf026, 32'h13, 2'h0);
        span(400);
        chk(cnt[2], 50, 2);
        wr(32'hf026, 32'h1e, 2'h0);
        span(400);
        chk(cnt[2], 25, 2);
        $display("rates done");
        pll_run_i <= 1;
        pll_lock_i <= 1;
        repeat (20) @(posedge ref_clk_i);
        pll_lock_i <= 0;
        @(posedge ref_clk_i);
        pll_lock_i <= 1;
        span(300);
        chk(cnt[3], 250);
        rd(32'hf025, 32'h400, 2'h0);
        pll_run_i <= 0;
        pll_lock_i <= 0;
        wr(32'hf006, 32'h0, 2'h0);
        pll_run_i <= 1;
        span(300);
        chk(cnt[3], 0);
        wr(32'hf006, 32'h1, 2'h0);
        span(100);
        chk(cnt[3], 49, 3);
        $display("watchdog done");
        // Reset in mid-run brings back the reset values
        resetn_i <= 0;
        @(posedge ref_clk_i);
        resetn_i <= 1;
        @(posedge ref_clk_i);
        rd(32'hf020, 32'h6, 2'h0);
        rd(32'hf026, 32'he, 2'h0);
        $display("reset done");
        test_done;
    end
endmodule // test_audio_clock_generator_config
